// ---- include/nand_host_pkg.sv ----
// Package with constants for the NAND flash host controller
package nand_host_pkg;
	// Clock period in ns
	localparam int CLK_PERIOD_NS = 10;
	// Pin timing figures in ns
	localparam int WRITE_PULSE_NS = 12;
	localparam int WRITE_HIGH_NS = 10;
	localparam int READ_PULSE_NS = 12;
	localparam int READ_HIGH_NS = 10;
	localparam int READ_ACCESS_NS = 20;
	localparam int WE_TO_RE_NS = 60;
	localparam int WE_TO_BUSY_NS = 100;
	// Cycle counts derived from the figures, least times rounded up
	localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_CYC = (READ_PULSE_NS + READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RH_CYC = (READ_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WHR_CYC = (WE_TO_RE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WB_CYC = (WE_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Busy limits in us, timeout counts
	localparam int READ_TIME_US = 120;
	localparam int PROG_TIME_US = 700;
	localparam int ERASE_TIME_US = 5000;
	localparam int RESET_TIME_US = 500;
	localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
	// Command codes
	localparam logic [7:0] CMD_READ1 = 8'h00;
	localparam logic [7:0] CMD_READ2 = 8'h30;
	localparam logic [7:0] CMD_COPY_RD = 8'h35;
	localparam logic [7:0] CMD_PROG1 = 8'h80;
	localparam logic [7:0] CMD_COPY_PR = 8'h85;
	localparam logic [7:0] CMD_PROG2 = 8'h10;
	localparam logic [7:0] CMD_ERASE1 = 8'h60;
	localparam logic [7:0] CMD_ERASE2 = 8'hd0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_ECC_STATUS = 8'h7a;
	localparam logic [7:0] CMD_RESET = 8'hff;
	// Geometry
	localparam int PAGE_BYTES = 2112;
	localparam int MAX_PARTIAL = 4;
	localparam int ECC_SECTORS = 4;
	// Status byte failure bit
	localparam int STATUS_FAIL_BIT = 1;
	// Register offsets of the control port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_COLUMN = 4'h1;
	localparam logic [3:0] REG_ROW = 4'h2;
	localparam logic [3:0] REG_DATA = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_ECC = 4'h5;
	localparam logic [3:0] REG_COUNT = 4'h6;
	// Operation codes written to the control register
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_PROG = 3'h2;
	localparam logic [2:0] OP_ERASE = 3'h3;
	localparam logic [2:0] OP_RESET = 3'h4;
	localparam logic [2:0] OP_COPY = 3'h5;
	localparam logic [2:0] OP_STATUS = 3'h6;
	localparam logic [2:0] OP_ECC = 3'h7;
	// Bit positions in the control register
	localparam int CTRL_WP_BIT = 8;
	localparam int CTRL_CE_BIT = 9;
	// Bit positions in the status register
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_FAIL_BIT = 2;
	localparam int ST_TMO_BIT = 3;
	localparam int ST_ERR_BIT = 4;
	localparam int ST_RBY_BIT = 5;
	localparam int ST_DVALID_BIT = 6;
	localparam int ST_PARTIAL_BIT = 7;
endpackage : nand_host_pkg

// ---- verilog/nand_host_ctrl.sv ----
// Host controller that drives a NAND flash through its pins
//
// Behaviour
// - Command byte sent with command latch high
// - Address bytes sent with address latch high
// - Write protect low blocks program and erase
// - Address sent as four cycles, column first; erase sends two row cycles only
// - At most four partial programs per page; the count restarts whenever a program goes to another row
// - Read all four ECC sector status bytes
// - ECC status only right after ready; the controller sends it whenever started from idle
// - No host drive while memory drives port
// - Copy-back is 00h-35h then 85h-10h
// - Page read is 00h, address, 30h
// - Program confirmed by 10h command
// - Erase is 60h then D0h
// - Strobes stay high during read busy
`timescale 1ns/10ps
module nand_host_ctrl
	import nand_host_pkg::*;
#(
	parameter int TMO_UNIT = CYC_PER_US
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic chip_select_n,
	output logic command_latch,
	output logic address_latch,
	output logic input_strobe_n,
	output logic output_strobe_n,
	output logic write_protect_n,
	input wire logic ready_busy_n,
	input wire logic [7:0] data_port_in,
	output logic [7:0] data_port_out,
	output logic data_port_oe
);
	// Sequencer states, Gray codes in the listed order
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_SETUP = 4'b0001,
		S_LOW = 4'b0011,
		S_HIGH = 4'b0010,
		S_WAITB = 4'b0110,
		S_BUSY = 4'b0111,
		S_RLOW = 4'b0101,
		S_RHIGH = 4'b0100,
		S_DONE = 4'b1100
	} state_type;
	// Kind of pin cycle
	typedef enum logic [1:0] {
		K_CMD = 2'h0,
		K_ADDR = 2'h1,
		K_DIN = 2'h2,
		K_DOUT = 2'h3
	} kind_type;
	// All module state
	typedef struct packed {
		state_type st;
		logic [2:0] op;
		logic [4:0] step;
		kind_type kind;
		logic [11:0] col;
		logic [15:0] row;
		logic [7:0] wdata;
		logic wfull;
		logic [7:0] rdata;
		logic dvalid;
		logic [7:0] status;
		logic [31:0] ecc;
		logic [11:0] count;
		logic [31:0] tmo;
		logic [3:0] tcnt;
		logic busy;
		logic done;
		logic fail;
		logic timeout;
		logic err;
		logic wp;
		logic ce;
		logic [2:0] partial;
		logic [15:0] last_row;
		logic [15:0] rdq;
		logic cle;
		logic ale;
		logic we_n;
		logic ostb_n;
		logic oe;
		logic [7:0] dout;
		logic [1:0] rb_sync;
		logic copy; // Program half of a copy-back in progress
		logic [7:0] din_meta; // First flop on the data pins
		logic [7:0] din_sync; // Second flop, the only one read
	} regs_type;

	regs_type r_ff, nxt_r;

	// Busy timeout for an operation in clock cycles
	function automatic logic [31:0] tmo_of(input logic [2:0] op);
		int us;
		us = READ_TIME_US;
		if (op == OP_PROG || op == OP_COPY) us = PROG_TIME_US;
		if (op == OP_ERASE) us = ERASE_TIME_US;
		if (op == OP_RESET) us = RESET_TIME_US;
		return 32'(us * TMO_UNIT);
	endfunction : tmo_of

	// Pin sequence: one step gives kind and byte; last flags end of script
	function automatic logic [10:0] script(input regs_type s);
		logic [7:0] b;
		kind_type k;
		logic fin;
		b = 8'h00;
		k = K_CMD;
		fin = 1'b0;
		unique case (s.op)
			OP_READ, OP_COPY: begin
				unique case (s.step)
					5'd0: b = CMD_READ1;
					5'd1: begin k = K_ADDR; b = s.col[7:0]; end
					5'd2: begin k = K_ADDR; b = {4'h0, s.col[11:8]}; end
					5'd3: begin k = K_ADDR; b = s.row[7:0]; end
					5'd4: begin k = K_ADDR; b = s.row[15:8]; end
					default: begin
						b = (s.op == OP_COPY) ? CMD_COPY_RD : CMD_READ2;
						fin = 1'b1;
					end
				endcase
			end
			OP_PROG: begin
				unique case (s.step)
					5'd0: b = (s.copy) ? CMD_COPY_PR : CMD_PROG1;
					5'd1: begin k = K_ADDR; b = s.col[7:0]; end
					5'd2: begin k = K_ADDR; b = {4'h0, s.col[11:8]}; end
					5'd3: begin k = K_ADDR; b = s.row[7:0]; end
					5'd4: begin k = K_ADDR; b = s.row[15:8]; end
					5'd5: begin k = K_DIN; b = s.wdata; end
					default: begin b = CMD_PROG2; fin = 1'b1; end
				endcase
			end
			OP_ERASE: begin
				unique case (s.step)
					5'd0: b = CMD_ERASE1;
					5'd1: begin k = K_ADDR; b = s.row[7:0]; end
					5'd2: begin k = K_ADDR; b = s.row[15:8]; end
					default: begin b = CMD_ERASE2; fin = 1'b1; end
				endcase
			end
			OP_STATUS, OP_ECC: begin
				if (s.step == 5'd0) begin
					b = (s.op == OP_ECC) ? CMD_ECC_STATUS : CMD_STATUS;
				end else begin
					k = K_DOUT;
					fin = (s.op == OP_STATUS) || (s.step == 5'(ECC_SECTORS));
				end
			end
			default: begin b = CMD_RESET; fin = 1'b1; end
		endcase
		return {fin, k, b};
	endfunction : script

	// Next state
	always_comb begin
		logic [10:0] sc;
		logic go;
		sc = 11'h000;
		go = 1'b0;
		nxt_r = r_ff;
		nxt_r.rb_sync = {r_ff.rb_sync[0], ready_busy_n}; // Two-flop sync
		nxt_r.rdq = 16'h0000;
		sc = script(r_ff);
		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				REG_CTRL: begin
					nxt_r.wp = reg_wdata[CTRL_WP_BIT];
					nxt_r.ce = reg_wdata[CTRL_CE_BIT];
					go = (reg_wdata[2:0] != 3'h0) && (r_ff.st == S_IDLE);
				end
				REG_COLUMN: nxt_r.col = reg_wdata[11:0];
				REG_ROW: nxt_r.row = reg_wdata;
				REG_DATA: begin nxt_r.wdata = reg_wdata[7:0]; nxt_r.wfull = 1'b1; end
				default: ;
			endcase
		end
		// Register reads
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: nxt_r.rdq = {6'h00, r_ff.ce, r_ff.wp, 5'h00, r_ff.op};
				REG_COLUMN: nxt_r.rdq = {4'h0, r_ff.col};
				REG_ROW: nxt_r.rdq = r_ff.row;
				REG_DATA: begin nxt_r.rdq = {8'h00, r_ff.rdata}; nxt_r.dvalid = 1'b0; end
				REG_STATUS: begin
					nxt_r.rdq = {r_ff.status, r_ff.partial == 3'(MAX_PARTIAL), r_ff.dvalid,
						r_ff.rb_sync[1], r_ff.err, r_ff.timeout, r_ff.fail, r_ff.done, r_ff.busy};
					nxt_r.timeout = 1'b0;
					nxt_r.err = 1'b0;
					nxt_r.done = 1'b0; // Done stays until software has seen it
				end
				REG_ECC: nxt_r.rdq = r_ff.ecc[15:0];
				REG_COUNT: nxt_r.rdq = {4'h0, r_ff.count};
				default: nxt_r.rdq = 16'h0000;
			endcase
		end
		// Start of an operation
		if (go) begin
			nxt_r.op = reg_wdata[2:0];
			nxt_r.step = 5'd0;
			nxt_r.count = 12'h000;
			nxt_r.ecc = 32'h0;
			nxt_r.fail = 1'b0;
			nxt_r.done = 1'b0;
			nxt_r.copy = 1'b0;
			nxt_r.st = S_SETUP;
			nxt_r.busy = 1'b1;
			if (reg_wdata[2:0] == OP_PROG || reg_wdata[2:0] == OP_COPY) begin
				if (r_ff.row != r_ff.last_row) nxt_r.partial = 3'h0;
				// Program refused when protected or partial limit spent
				if (!reg_wdata[CTRL_WP_BIT] || (r_ff.row == r_ff.last_row &&
						r_ff.partial == 3'(MAX_PARTIAL))) begin
					nxt_r.st = S_IDLE;
					nxt_r.busy = 1'b0;
					nxt_r.err = 1'b1;
				end
			end
			if (reg_wdata[2:0] == OP_ERASE && !reg_wdata[CTRL_WP_BIT]) begin
				nxt_r.st = S_IDLE;
				nxt_r.busy = 1'b0;
				nxt_r.err = 1'b1;
			end
		end
		// Data pins pass two flops before any logic reads them
		nxt_r.din_meta = data_port_in;
		nxt_r.din_sync = r_ff.din_meta;
		// Pin sequencer
		nxt_r.tcnt = (r_ff.tcnt != 4'h0) ? r_ff.tcnt - 4'h1 : 4'h0;
		unique case (r_ff.st)
			S_IDLE: begin
				nxt_r.cle = 1'b0;
				nxt_r.ale = 1'b0;
			end
			S_SETUP: begin
				if (r_ff.tcnt == 4'h0 && !(sc[9:8] == K_DIN && !r_ff.wfull)) begin
					nxt_r.kind = kind_type'(sc[9:8]);
					nxt_r.cle = (sc[9:8] == K_CMD);
					nxt_r.ale = (sc[9:8] == K_ADDR);
					if (sc[9:8] == K_DOUT) begin
						nxt_r.oe = 1'b0;
						nxt_r.ostb_n = 1'b0;
						nxt_r.tcnt = 4'(RP_CYC);
						nxt_r.st = S_RLOW;
					end else begin
						nxt_r.oe = 1'b1;
						nxt_r.dout = sc[7:0];
						nxt_r.we_n = 1'b0;
						nxt_r.tcnt = 4'(WP_CYC);
						nxt_r.st = S_LOW;
					end
				end
			end
			S_LOW: begin
				if (r_ff.tcnt == 4'h1) begin
					nxt_r.we_n = 1'b1; // Latch edge
					nxt_r.tcnt = 4'(WH_CYC);
					nxt_r.st = S_HIGH;
				end
			end
			S_HIGH: begin
				if (r_ff.tcnt == 4'h1) begin
					nxt_r.oe = 1'b0;
					nxt_r.cle = 1'b0;
					nxt_r.ale = 1'b0;
					if (r_ff.kind == K_DIN) begin
						// A byte written in this very cycle is kept
						if (!(reg_wr && reg_addr == REG_DATA)) nxt_r.wfull = 1'b0;
						nxt_r.count = r_ff.count + 12'h001;
						if (r_ff.count == 12'(PAGE_BYTES - 1)) nxt_r.step = r_ff.step + 5'd1;
					end else begin
						nxt_r.step = r_ff.step + 5'd1;
					end
					if (r_ff.kind == K_DIN && r_ff.wfull == 1'b0) nxt_r.st = S_SETUP;
					if (sc[10]) begin
						nxt_r.tmo = tmo_of(r_ff.op);
						nxt_r.tcnt = 4'(WB_CYC);
						nxt_r.st = S_WAITB;
					end else if (r_ff.op == OP_STATUS || r_ff.op == OP_ECC) begin
						nxt_r.tcnt = 4'(WHR_CYC);
						nxt_r.st = S_SETUP;
					end else begin
						nxt_r.st = S_SETUP;
					end
				end
			end
			S_WAITB: begin
				if (r_ff.tcnt == 4'h0) nxt_r.st = S_BUSY; // Busy shows within tWB
			end
			S_BUSY: begin
				// Strobes held high, waiting for ready
				nxt_r.tmo = r_ff.tmo - 32'h1;
				if (r_ff.rb_sync[1]) begin
					if (r_ff.op == OP_COPY) begin
						// Second half reuses the program path with its own command
						nxt_r.op = OP_PROG;
						nxt_r.copy = 1'b1;
						nxt_r.step = 5'd0;
						nxt_r.st = S_SETUP;
					end else if (r_ff.op == OP_READ) begin
						nxt_r.op = OP_STATUS;
						nxt_r.step = 5'd1;
						nxt_r.count = r_ff.col;
						nxt_r.st = S_DONE;
					end else begin
						nxt_r.st = S_DONE;
					end
					if (r_ff.op == OP_PROG) begin
						nxt_r.partial = r_ff.partial + 3'h1;
						nxt_r.last_row = r_ff.row;
					end
				end else if (r_ff.tmo == 32'h0) begin
					nxt_r.timeout = 1'b1;
					nxt_r.st = S_DONE;
				end
			end
			S_RLOW: begin
				if (r_ff.tcnt == 4'h1) begin
					nxt_r.rdata = r_ff.din_sync;
					nxt_r.dvalid = 1'b1;
					if (r_ff.op == OP_ECC) begin
						nxt_r.ecc = {r_ff.ecc[23:0], r_ff.din_sync};
					end else begin
						nxt_r.status = r_ff.din_sync;
						nxt_r.fail = r_ff.din_sync[STATUS_FAIL_BIT];
					end
					nxt_r.ostb_n = 1'b1;
					nxt_r.tcnt = 4'(RH_CYC);
					nxt_r.st = S_RHIGH;
				end
			end
			S_RHIGH: begin
				if (r_ff.tcnt == 4'h1) begin
					nxt_r.step = r_ff.step + 5'd1;
					nxt_r.count = r_ff.count + 12'h001;
					nxt_r.st = sc[10] ? S_DONE : S_SETUP;
				end
			end
			S_DONE: begin
				nxt_r.busy = 1'b0;
				nxt_r.done = 1'b1;
				nxt_r.st = S_IDLE;
			end
			default: nxt_r.st = S_IDLE;
		endcase
		// Chip select released only when idle and asked, so standby is entered when ready
		if (r_ff.st != S_IDLE) nxt_r.ce = 1'b1;
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r_ff <= '{st: S_IDLE, kind: K_CMD, we_n: 1'b1, ostb_n: 1'b1, default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs
	assign reg_rdata = r_ff.rdq;
	assign chip_select_n = ~r_ff.ce;
	assign command_latch = r_ff.cle;
	assign address_latch = r_ff.ale;
	assign input_strobe_n = r_ff.we_n;
	assign output_strobe_n = r_ff.ostb_n;
	assign write_protect_n = r_ff.wp;
	assign data_port_out = r_ff.dout;
	assign data_port_oe = r_ff.oe;
endmodule : nand_host_ctrl

// ---- test/nand_host_ctrl_assertions.sv ----
// Checker of pin timing and port behaviour of the flash host controller
`timescale 1ns/10ps
module nand_host_ctrl_checker
	import nand_host_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic chip_select_n,
	input wire logic command_latch,
	input wire logic address_latch,
	input wire logic input_strobe_n,
	input wire logic output_strobe_n,
	input wire logic write_protect_n,
	input wire logic ready_busy_n,
	input wire logic [7:0] data_port_in,
	input wire logic [7:0] data_port_out,
	input wire logic data_port_oe
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Write strobe: two cycles low, one high
	sequence s_wr_pulse;
		!input_strobe_n [*2] ##1 input_strobe_n;
	endsequence
	// Read strobe: four cycles low, one high
	sequence s_rd_pulse;
		!output_strobe_n [*4] ##1 output_strobe_n;
	endsequence
	// Both strobes left alone while the memory starts work
	sequence s_quiet;
		(input_strobe_n && output_strobe_n) [*8];
	endsequence
	property p_reset_idle;
		$fell(rst) |-> chip_select_n && !write_protect_n && input_strobe_n && output_strobe_n
			&& !command_latch && !address_latch && !data_port_oe;
	endproperty
	property p_wr_pulse;
		$fell(input_strobe_n) |-> s_wr_pulse;
	endproperty
	property p_rd_pulse;
		$fell(output_strobe_n) |-> s_rd_pulse;
	endproperty
	property p_latch_cycle;
		(command_latch || address_latch) && !input_strobe_n |-> data_port_oe && !chip_select_n
			&& !(command_latch && address_latch);
	endproperty
	property p_no_clash;
		!output_strobe_n |-> !data_port_oe && input_strobe_n;
	endproperty
	property p_busy_hold;
		!ready_busy_n [*3] |-> input_strobe_n && output_strobe_n;
	endproperty
	property p_wp_guard;
		!write_protect_n && command_latch && !input_strobe_n |-> data_port_out != CMD_PROG2
			&& data_port_out != CMD_ERASE2;
	endproperty
	property p_start_wait;
		$rose(input_strobe_n) && command_latch && (data_port_out == CMD_READ2
			|| data_port_out == CMD_PROG2 || data_port_out == CMD_ERASE2) |=> s_quiet;
	endproperty
	property p_rdata_idle;
		!reg_rd |=> reg_rdata == 16'h0;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe shape");
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe shape");
	a_latch_cycle: assert property (p_latch_cycle) else $error("latch cycle");
	a_no_clash: assert property (p_no_clash) else $error("port contention");
	a_busy_hold: assert property (p_busy_hold) else $error("strobe while busy");
	a_wp_guard: assert property (p_wp_guard) else $error("start while protected");
	a_start_wait: assert property (p_start_wait) else $error("no busy wait");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule : nand_host_ctrl_checker
bind nand_host_ctrl nand_host_ctrl_checker chk (.*);

// ---- test/nand_flash_model.sv ----
// Behavioural flash memory answering the host controller
`timescale 1ns/10ps
module nand_flash_model
	import nand_host_pkg::*;
#(
	parameter int BUSY_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic chip_select_n,
	input wire logic command_latch,
	input wire logic address_latch,
	input wire logic input_strobe_n,
	input wire logic output_strobe_n,
	input wire logic write_protect_n,
	input wire logic [7:0] data_port_in,
	input wire logic fail_set,
	output logic busy_low,
	output logic [7:0] mem_dout
);
	logic [7:0] start_cmd = 8'h0; // Command that began the last busy spell
	logic [7:0] last_data = 8'h0; // Last data byte taken
	logic [7:0] addr_q [4]; // Address cycles in arrival order
	logic [11:0] col = 12'h0; // Column counter
	logic fail = 1'b0; // Outcome of last operation
	logic saw_copy = 1'b0; // Copy program command seen
	int mode = 0; // 0 page data, 1 status, 2 sector status
	int addr_n = 0;
	int data_n = 0;
	int busy_n = 0;
	int ops = 0;
	int ecc_n = 0;
	initial mem_dout = 8'h0;
	assign busy_low = busy_n != 0; // Open drain pulled low while busy
	// Busy countdown, well inside the limits
	// Counted after the edge so the host never races the pin change
	always @(posedge sys_clk) if (busy_n != 0) busy_n <= busy_n - 1;
	// Pins shut out in standby and while busy
	always @(posedge input_strobe_n) if (!chip_select_n && busy_n == 0) begin
		if (command_latch) begin
			mode = 0;
			case (data_port_in)
				CMD_READ1, CMD_ERASE1: addr_n = 0;
				CMD_PROG1, CMD_COPY_PR: begin
					addr_n = 0;
					data_n = 0;
					saw_copy = data_port_in == CMD_COPY_PR;
				end
				CMD_READ2, CMD_COPY_RD: begin
					col = {addr_q[1][3:0], addr_q[0]};
					start_cmd = data_port_in;
					busy_n = BUSY_CYC;
				end
				CMD_PROG2, CMD_ERASE2: if (write_protect_n) begin
					ops++;
					fail = fail_set;
					start_cmd = data_port_in;
					busy_n = BUSY_CYC;
				end
				CMD_STATUS: mode = 1;
				CMD_ECC_STATUS: begin
					mode = 2;
					ecc_n = 0;
				end
				CMD_RESET: begin
					fail = 1'b0;
					start_cmd = data_port_in;
					busy_n = 4;
				end
				default: ;
			endcase
		end else if (address_latch) begin
			addr_q[addr_n % 4] = data_port_in;
			addr_n++;
		end else begin
			last_data = data_port_in;
			data_n++;
		end
	end
	// Each read strobe fall puts out a byte; page data also steps the column
	always @(negedge output_strobe_n) if (!chip_select_n) begin
		case (mode)
			1: mem_dout = {1'b0, busy_n == 0, 4'h0, fail, 1'b0};
			2: begin
				mem_dout = 8'h21;
				ecc_n++;
			end
			default: begin
				mem_dout = col[7:0];
				col++;
			end
		endcase
	end
	// Long high time: drivers off after the hold
	always @(posedge output_strobe_n) begin
		#25;
		if (output_strobe_n) mem_dout = ~mem_dout;
	end
	// Short high time: released by latch, select or write strobe
	always @(posedge command_latch or posedge address_latch or posedge chip_select_n
		or negedge input_strobe_n) mem_dout = ~mem_dout;
endmodule : nand_flash_model

// ---- test/nand_host_ctrl_tb.sv ----
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
module nand_host_ctrl_tb;
	import nand_host_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic fail_set = 1'b0; // Memory reports failure when set
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0;
	logic [15:0] reg_rdata, st;
	logic chip_select_n, command_latch, address_latch, input_strobe_n, output_strobe_n;
	logic write_protect_n, data_port_oe, busy_low;
	logic [7:0] data_port_out, mem_dout;
	wire ready_busy_n;
	wire [7:0] data_port_in;
	int fail_count = 0;
	int checks = 0;
	assign ready_busy_n = !busy_low; // Pull-up on open drain
	assign data_port_in = data_port_oe ? data_port_out : mem_dout;
	always #5 sys_clk = ~sys_clk;
	nand_host_ctrl #(.TMO_UNIT(1)) DUT (.*);
	nand_flash_model mdl (.*);
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	// Polls status until busy clears
	task automatic wait_idle();
		for (int i = 0; i < 20000; i++) begin
			reg_read(REG_STATUS, st);
			if (st[ST_BUSY_BIT] === 1'b0) break;
		end
	endtask : wait_idle
	task automatic run_op(input logic [2:0] op, input logic wp);
		reg_write(REG_CTRL, {6'h0, 1'b1, wp, 5'h0, op});
		wait_idle();
	endtask : run_op
	task automatic t_idle();
		logic [15:0] d;
		check("idle pins", 16'({chip_select_n, write_protect_n, input_strobe_n,
			output_strobe_n, data_port_oe}), 16'h0016);
		reg_read(REG_STATUS, d);
		check("status after reset", d & 16'h003f, 16'h0020);
		reg_read(4'hf, d);
		check("unmapped read", d, 16'h0);
	endtask : t_idle
	task automatic t_erase();
		int n;
		n = mdl.ops;
		reg_write(REG_ROW, 16'h0a5c);
		run_op(OP_ERASE, 1'b0);
		check("refused erase err", 16'(st[ST_ERR_BIT]), 16'h1);
		check("refused erase ops", 16'(mdl.ops - n), 16'h0);
		run_op(OP_ERASE, 1'b1);
		check("erase row", {mdl.addr_q[1], mdl.addr_q[0]}, 16'h0a5c);
		check("erase start", 16'(mdl.start_cmd), 16'(CMD_ERASE2));
		check("erase done", 16'(st[ST_DONE_BIT]), 16'h1);
	endtask : t_erase
	task automatic t_read();
		logic [15:0] d;
		reg_write(REG_COLUMN, 16'h0123);
		reg_write(REG_ROW, 16'h4567);
		run_op(OP_READ, 1'b1);
		check("column cycles", {mdl.addr_q[1], mdl.addr_q[0]}, 16'h0123);
		check("row cycles", {mdl.addr_q[3], mdl.addr_q[2]}, 16'h4567);
		check("read start", 16'(mdl.start_cmd), 16'(CMD_READ2));
		run_op(OP_ECC, 1'b1);
		reg_read(REG_ECC, d);
		check("sector status", d, 16'h2121);
		check("sector reads", 16'(mdl.ecc_n), 16'h4);
	endtask : t_read
	// Whole page program or copy, with chosen outcome
	task automatic t_prog(input logic [2:0] op, input logic f);
		fail_set <= f;
		reg_write(REG_COLUMN, 16'h0);
		reg_write(REG_ROW, 16'h0041);
		reg_write(REG_CTRL, {6'h0, 2'h3, 5'h0, op});
		for (int i = 0; i < PAGE_BYTES; i++) begin
			reg_write(REG_DATA, 16'(i % 256));
			wait (mdl.data_n == i + 1);
		end
		wait_idle();
		check("page bytes", 16'(mdl.data_n), 16'(PAGE_BYTES));
		check("last byte", 16'(mdl.last_data), 16'((PAGE_BYTES - 1) % 256));
		check("program start", 16'(mdl.start_cmd), 16'(CMD_PROG2));
		check("copy command", 16'(mdl.saw_copy), 16'(op == OP_COPY));
		// Outcome is only known after a status read
		run_op(OP_STATUS, 1'b1);
		check("fail flag", 16'(st[ST_FAIL_BIT]), 16'(f));
		check("status byte", 16'(st[15:8]), 16'({2'h1, 4'h0, f, 1'b0}));
	endtask : t_prog
	task automatic t_reset();
		// Sent while protected, so the protect guard sees a command cycle
		run_op(OP_RESET, 1'b0);
		check("reset command", 16'(mdl.start_cmd), 16'(CMD_RESET));
	endtask : t_reset
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		t_idle();
		t_erase();
		t_read();
		t_prog(OP_PROG, 1'b0);
		t_prog(OP_COPY, 1'b1);
		t_reset();
		give_verdict();
	end
	// Watchdog against a hang
	initial begin
		#1000000;
		fail_count++;
		give_verdict();
	end
endmodule : nand_host_ctrl_tb
